// ==== usart_clock_and_buffering_tb_top.sv ====
// self-checking bench for the serial transceiver core
// assumes the checker is bound and the serial peer sits on the pins
`timescale 1ns/1ps
module usart_clock_and_buffering_tb_top;
  import usc_pkg::*;
  // design inputs
  logic              i_clk = 1'b0, i_arst_n = 1'b0, i_double_speed_select = 1'b0;
  usc_mode_t         i_clock_mode = USC_ASYNC;
  logic [11:0]       i_baud_period_setting = 12'h001;
  logic signed [3:0] i_baud_scale_exponent = 4'sh1;
  logic              i_tx_enable = 1'b1, i_rx_enable = 1'b1, i_parity_en = 1'b0, i_parity_odd = 1'b0;
  logic              i_one_wire = 1'b0, i_multiproc = 1'b0, i_tx_valid = 1'b0, i_rx_ready = 1'b0;
  logic              i_tx_complete_clr = 1'b0;
  logic [3:0]        i_char_bits = 4'h8;
  logic [8:0]        i_tx_data = 9'h000;
  // design outputs and lines
  logic              o_tx_ready, o_rx_valid, o_rx_frame_err, o_rx_parity_err, o_rx_overflow, o_rx_complete;
  logic              o_tx_complete, o_data_empty, o_txd, o_rxd_out, o_rxd_oe, o_xck, o_xck_oe, peer_line;
  logic [8:0]        o_rx_data;
  wire               i_rxd   = o_rxd_oe ? o_rxd_out : peer_line;
  wire               peer_in = i_one_wire ? i_rxd : o_txd;
  // model state
  int                miscompares = 0, compares = 0, n;
  logic [8:0]        txq[$], rxq[$];
  logic [7:0]        d;

  always #2.5 i_clk = ~i_clk;

  usc_core i_dut (.i_clk, .i_arst_n, .i_clock_mode, .i_double_speed_select, .i_baud_period_setting,
    .i_baud_scale_exponent, .i_tx_enable, .i_rx_enable, .i_char_bits, .i_parity_en, .i_parity_odd,
    .i_two_stop(1'b0), .i_msb_first(1'b0), .i_one_wire, .i_multiproc, .i_ext_len_en(1'b0),
    .i_frame_length_counter(4'h0), .i_tx_valid, .i_tx_data, .o_tx_ready, .o_rx_valid, .i_rx_ready, .o_rx_data,
    .o_rx_frame_err, .o_rx_parity_err, .o_rx_overflow, .o_rx_complete, .o_tx_complete, .i_tx_complete_clr,
    .o_data_empty, .o_txd, .i_rxd, .o_rxd_out, .o_rxd_oe, .i_xck(1'b0), .o_xck, .o_xck_oe);
  usc_serial_peer i_peer (.i_clk, .i_line(peer_in), .o_line(peer_line));

  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic miss(input string m);
    miscompares++;
    $display("wrong value at %0t: %s", $time, m);
  endtask : miss
  task automatic chk_data(input logic [8:0] e, input logic [8:0] g);
    compares++;
    if (g !== e) miss($sformatf("data %h expected %h", g, e));
  endtask : chk_data
  task automatic chk_flag(input logic e, input logic g);
    compares++;
    if (g !== e) miss($sformatf("flag %b expected %b", g, e));
  endtask : chk_flag
  task automatic chk_count(input int e, input int g);
    compares++;
    if (g != e) miss($sformatf("count %0d expected %0d", g, e));
  endtask : chk_count
  // bounded wait: 0 rx valid, 1 tx complete, 2 clock pin, 3 peer word
  function automatic logic pick(input int s);
    return s == 0 ? o_rx_valid : s == 1 ? o_tx_complete : s == 2 ? o_xck : logic'(i_peer.got.size() > 0);
  endfunction : pick
  task automatic wait_hi(input int s);
    n = 0;
    while (pick(s) !== 1'b1 && n < 20000) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 20000) begin
      miss("wait ran out");
      tally_and_finish();
    end
  endtask : wait_hi
  // write one word, valid held for back-to-back use
  task automatic wr(input logic [8:0] w);
    i_tx_valid <= 1'b1;
    i_tx_data  <= w;
    n = 0;
    // ready looked at mid-cycle, so the taking edge is the next rising one
    do begin
      @(negedge i_clk);
      n++;
    end while (o_tx_ready !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      miss("write not taken");
      tally_and_finish();
    end
    @(posedge i_clk);
  endtask : wr
  task automatic pop(input logic [8:0] e);
    wait_hi(0);
    chk_data(e, o_rx_data);
    i_rx_ready <= 1'b1;
    @(posedge i_clk);
    i_rx_ready <= 1'b0;
    @(posedge i_clk);
  endtask : pop
  task automatic clr_txc;
    wait_hi(1);
    chk_flag(1'b1, o_data_empty);
    i_tx_complete_clr <= 1'b1;
    @(posedge i_clk);
    i_tx_complete_clr <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk_flag(1'b0, o_tx_complete);
  endtask : clr_txc

  initial begin
    void'($urandom(32'h27F7));
    repeat (5) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk_flag(1'b1, o_data_empty);
    chk_flag(1'b0, o_rx_valid);
    chk_flag(1'b1, o_txd);
    $display("test reset done");
    // three words back to back at normal then double speed
    for (int s = 0; s < 2; s++) begin
      i_double_speed_select <= s[0];
      i_peer.bit_clks = (s ? 8 : 16) * 4;
      @(posedge i_clk);
      for (int k = 0; k < 3; k++) begin
        txq.push_back({1'b0, 8'($urandom_range(255))});
        wr(txq[k]);
      end
      i_tx_valid <= 1'b0;
      for (int k = 0; k < 3; k++) begin
        wait_hi(3);
        chk_data(txq.pop_front(), {1'b0, i_peer.got.pop_front()});
      end
      clr_txc();
      $display("test transmit speed %0d done", s);
    end
    // five-bit characters: stop bit and idle line fill the top
    i_char_bits <= 4'h5;
    d = 8'($urandom_range(255));
    wr({1'b0, d});
    i_tx_valid <= 1'b0;
    wait_hi(3);
    chk_data({4'h7, d[4:0]}, {1'b0, i_peer.got.pop_front()});
    clr_txc();
    i_char_bits <= 4'h8;
    $display("test short character done");
    // three frames unread: the third is lost and flagged
    for (int k = 0; k < 3; k++) begin
      d = 8'($urandom_range(255));
      if (k < 2) rxq.push_back({1'b0, d});
      i_peer.send(d, 1'b0, 1'b0, 1'b1);
    end
    chk_flag(1'b1, o_rx_overflow);
    pop(rxq.pop_front());
    chk_flag(1'b0, o_rx_overflow);
    pop(rxq.pop_front());
    // stop bit held low
    d = 8'($urandom_range(255));
    i_peer.send(d, 1'b0, 1'b0, 1'b0);
    wait_hi(0);
    chk_flag(1'b1, o_rx_frame_err);
    pop({1'b0, d});
    $display("test receive errors done");
    // parity of both senses, right then wrong
    i_parity_en <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      i_parity_odd <= k[1];
      @(posedge i_clk);
      d = 8'($urandom_range(255));
      i_peer.send(d, 1'b1, ^d ^ k[1] ^ k[0], 1'b1);
      wait_hi(0);
      chk_flag(k[0], o_rx_parity_err);
      pop({1'b0, d});
    end
    i_parity_en <= 1'b0;
    // multiprocessor: a frame with a clear top bit is dropped
    i_multiproc <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      d = {k[0], 7'($urandom_range(127))};
      i_peer.send(d, 1'b0, 1'b0, 1'b1);
    end
    pop({1'b0, d});
    chk_flag(1'b0, o_rx_valid);
    i_multiproc <= 1'b0;
    $display("test parity and address done");
    // one-wire: the core drives the shared receive pin
    i_one_wire  <= 1'b1;
    i_rx_enable <= 1'b0;
    @(posedge i_clk);
    d = 8'($urandom_range(255));
    wr({1'b0, d});
    i_tx_valid <= 1'b0;
    wait_hi(3);
    chk_data({1'b0, d}, {1'b0, i_peer.got.pop_front()});
    clr_txc();
    i_one_wire  <= 1'b0;
    i_rx_enable <= 1'b1;
    $display("test one-wire done");
    // synchronous master: clock pin period is twice period plus one
    i_peer.rx_on = 1'b0;
    i_clock_mode <= USC_SYNC_MST;
    i_baud_scale_exponent <= 4'sh0;
    i_baud_period_setting <= 12'($urandom_range(7));
    @(posedge i_clk);
    wr({1'b0, 8'($urandom_range(255))});
    i_tx_valid <= 1'b0;
    wait_hi(2);
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_xck !== 1'b0 && n < 99);
    do begin
      @(posedge i_clk);
      n++;
    end while (o_xck !== 1'b1 && n < 99);
    chk_count(2 * (i_baud_period_setting + 1), n);
    clr_txc();
    $display("test synchronous master done");
    tally_and_finish();
  end
endmodule : usart_clock_and_buffering_tb_top

// ==== usc_baud_gen.sv ====
// fractional rate generator: down-counter giving one tick per expiry
// assumes synchronised active-low reset from the core
`timescale 1ns/1ps
module usc_baud_gen (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // settings in, tick out
  usc_baud_if.gen   bif
);
  import usc_pkg::*;
  typedef struct packed {
    logic [`USC_CNT_W-1:0]  cnt;
    logic [`USC_FRAC_W-1:0] acc;
    logic                   tick;
  } usc_gen_st_t;
  usc_gen_st_t st_q, st_d;
  logic [2:0]  mag;
  logic [6:0]  frac;
  logic [7:0]  sum;

  // reload and fractional carry
  always_comb begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    mag  = bif.exponent[3] ? 3'(-bif.exponent) : bif.exponent[2:0];
    frac = 7'((bif.period & ((12'h1 << mag) - 12'h1)) << (3'h7 - mag));
    sum  = {1'b0, st_q.acc} + {1'b0, frac};
    if (st_q.cnt == 20'h0) begin
      st_d.tick = 1'b1;
      if (bif.sync_mode) begin
        st_d.cnt = {8'h0, bif.period};
      end else if (!bif.exponent[3]) begin
        st_d.cnt = 20'((({8'h0, bif.period} + 20'h1) << mag) - 20'h1);
      end else begin
        st_d.acc = sum[6:0];
        st_d.cnt = {8'h0, bif.period >> mag} + {19'h0, sum[7]};
      end
    end else begin
      st_d.cnt = st_q.cnt - 20'h1;
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign bif.tick = st_q.tick;
endmodule : usc_baud_gen

// ==== usc_baud_if.sv ====
// carrier between the core and its fractional rate generator
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface usc_baud_if;
  logic [11:0]       period;
  logic signed [3:0] exponent;
  logic              sync_mode;
  logic              tick;
  modport gen  (input period, exponent, sync_mode, output tick);
  modport core (output period, exponent, sync_mode, input tick);
endinterface : usc_baud_if

// ==== usc_core.sv ====
// serial transceiver core: rate generation, buffered transmitter and receiver
// assumes synchronous pin inputs and software keeping its setting limits
// Behaviour
// - normal speed rate is clock over 16 times scaled period plus one.
// - double speed uses factor 8 instead of 16.
// - synchronous and SPI master rate is clock over twice period plus one.
// - synchronous up to half clock, asynchronous up to one eighth.
// - four clock modes from internal generator or external transfer clock.
// - external transfer clock only in synchronous slave mode.
// - double speed halves receiver samples per bit from 16 to 8.
// - frames of five to nine bits, optional parity, one or two stops.
// - one write buffer ahead of the shifter allows gapless frames.
// - two-entry receive buffer; frame, overflow and parity errors detected.
// - one-wire mode shares the receive pin for both directions.
// - SPI master drops start, stop, parity, filter and address logic.
// - separate receive complete, transmit complete and buffer empty events.
// - frame error and overflow flagged separately; parity optional.
// - receiver majority filter and false start bit rejection.
// - unaddressed multiprocessor receiver discards frames.
// - external frame length counter sets the data bit count.
`timescale 1ns/1ps
module usc_core (
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_arst_n,
  // configuration
  input  wire usc_pkg::usc_mode_t i_clock_mode,
  input  wire logic               i_double_speed_select,
  input  wire logic [11:0]        i_baud_period_setting,
  input  wire logic signed [3:0]  i_baud_scale_exponent,
  input  wire logic               i_tx_enable,
  input  wire logic               i_rx_enable,
  input  wire logic [3:0]         i_char_bits,
  input  wire logic               i_parity_en,
  input  wire logic               i_parity_odd,
  input  wire logic               i_two_stop,
  input  wire logic               i_msb_first,
  input  wire logic               i_one_wire,
  input  wire logic               i_multiproc,
  input  wire logic               i_ext_len_en,
  input  wire logic [3:0]         i_frame_length_counter,
  // transmit write port
  input  wire logic               i_tx_valid,
  input  wire logic [8:0]         i_tx_data,
  output logic                    o_tx_ready,
  // receive read port
  output logic                    o_rx_valid,
  input  wire logic               i_rx_ready,
  output logic [8:0]              o_rx_data,
  output logic                    o_rx_frame_err,
  output logic                    o_rx_parity_err,
  output logic                    o_rx_overflow,
  // events
  output logic                    o_rx_complete,
  output logic                    o_tx_complete,
  input  wire logic               i_tx_complete_clr,
  output logic                    o_data_empty,
  // serial pins
  output logic                    o_txd,
  input  wire logic               i_rxd,
  output logic                    o_rxd_out,
  output logic                    o_rxd_oe,
  input  wire logic               i_xck,
  output logic                    o_xck,
  output logic                    o_xck_oe
);
  import usc_pkg::*;

  typedef struct packed {
    usc_tx_st_t            tx_st;
    logic                  tx_full;
    logic [8:0]            tx_buf;
    logic [12:0]           tx_sh;
    logic [3:0]            tx_idx;
    logic [3:0]            tx_len;
    logic [4:0]            tx_os;
    logic                  tx_done;
    logic                  transfer_clock_pin;
    logic                  xck_in_q;
    usc_rx_st_t            rx_st;
    logic [2:0]            flt;
    logic [10:0]           rx_sh;
    logic [3:0]            rx_idx;
    logic [4:0]            rx_os;
    usc_rx_ent_t [1:0]     ent;
    logic                  wr;
    logic                  rd;
    logic [1:0]            cnt;
    logic                  ovf;
  } usc_core_st_t;

  usc_core_st_t st_q, st_d;
  logic [1:0]   rst_q;
  logic         rst_n;
  logic         is_spi, is_slv, is_mst, is_sync, par, tick;
  logic         tx_busy, tx_go, tx_last, rise, fall, mchg, chg, maj, line;
  logic [3:0]   n_bits, target;
  logic [4:0]   os_n;
  logic [16:0]  bf;
  logic         take, fin, drop, pop, val;
  logic [3:0]   pos;
  usc_rx_ent_t  word;

  usc_baud_if bif ();

  // fractional rate generator
  usc_baud_gen u_gen (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .bif     (bif.gen)
  );

  // low n bits set
  function automatic logic [10:0] mask11(input logic [3:0] n);
    return 11'((12'h1 << n) - 12'h1);
  endfunction : mask11

  // bit reversal for msb-first SPI
  function automatic logic [7:0] rev8(input logic [7:0] d);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = d[7 - i];
    return r;
  endfunction : rev8

  // data bit count limited to 1..9
  function automatic logic [3:0] len_clamp(input logic [3:0] v);
    return (v == 4'h0) ? 4'h1 : ((v > `USC_MAX_BITS) ? `USC_MAX_BITS : v);
  endfunction : len_clamp

  // frame bits lsb first, with length on top
  function automatic logic [16:0] build_frame(input logic [8:0] d, input logic [3:0] n,
                                              input logic p, input logic spi);
    logic [12:0] f;
    logic [3:0]  len;
    logic [8:0]  dd;
    dd  = d & 9'(mask11(n));
    f   = 13'h1FFF;
    if (spi) begin
      if (i_msb_first && !i_ext_len_en) dd = {1'b0, rev8(d[7:0])};
      f[8:0] = dd;
      len    = n;
    end else begin
      f[0] = 1'b0;
      for (int i = 0; i < 9; i++) if (4'(i) < n) f[i + 1] = dd[i];
      if (p) f[n + 4'h1] = (^dd) ^ i_parity_odd;
      len = 4'(n + {3'h0, p} + 4'h2 + {3'h0, i_two_stop});
    end
    return {len, f};
  endfunction : build_frame

  // reset release through two flops
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // mode decode and frame shape
  assign is_spi  = (i_clock_mode == USC_SPI_MST);
  assign is_slv  = (i_clock_mode == USC_SYNC_SLV);
  assign is_mst  = (i_clock_mode == USC_SYNC_MST) | is_spi;
  assign is_sync = is_mst | is_slv;
  assign n_bits  = i_ext_len_en ? len_clamp(i_frame_length_counter)
                 : (is_spi ? `USC_SPI_BITS : len_clamp(i_char_bits));
  assign par     = i_parity_en & ~is_spi & ~i_ext_len_en;
  assign target  = is_spi ? n_bits : 4'(n_bits + {3'h0, par} + 4'h1);
  assign os_n    = i_double_speed_select ? `USC_OS_DOUBLE : `USC_OS_NORMAL;
  assign bf      = build_frame(st_q.tx_buf, n_bits, par, is_spi);

  // generator settings
  assign bif.period    = i_baud_period_setting;
  assign bif.exponent  = i_baud_scale_exponent;
  assign bif.sync_mode = is_sync;
  assign tick          = bif.tick;

  // bit timing events
  assign tx_busy = (st_q.tx_st == TX_SHIFT);
  assign tx_go   = st_q.tx_full & i_tx_enable;
  assign tx_last = tx_busy & (st_q.tx_idx == st_q.tx_len - 4'h1);
  assign mchg    = is_mst & tick & ~st_q.transfer_clock_pin & (tx_busy | tx_go);
  assign rise    = is_slv & ~st_q.xck_in_q & i_xck;
  assign fall    = is_slv ? (st_q.xck_in_q & ~i_xck) : (is_mst & tick & st_q.transfer_clock_pin);
  assign chg     = is_slv ? rise : (is_mst ? mchg : tick & (~tx_busy | (st_q.tx_os == os_n - 5'h1)));
  assign maj     = (st_q.flt[0] & st_q.flt[1]) | (st_q.flt[0] & st_q.flt[2]) | (st_q.flt[1] & st_q.flt[2]);
  assign pop     = (st_q.cnt != 2'h0) & i_rx_ready;

  // next state
  always_comb begin
    st_d = st_q;
    take = 1'b0;
    pos  = st_q.rx_idx;
    val  = is_spi ? i_rxd : maj;
    fin  = 1'b0;
    drop = 1'b0;
    word = '0;
    // transmit complete clear, set below wins
    if (i_tx_complete_clr) st_d.tx_done = 1'b0;
    // async oversample count per bit
    if (tick && tx_busy && !is_sync) st_d.tx_os = (st_q.tx_os == os_n - 5'h1) ? 5'h0 : st_q.tx_os + 5'h1;
    // shift, reload or finish
    if (chg) begin
      if (tx_busy && !tx_last) begin
        st_d.tx_sh  = {1'b1, st_q.tx_sh[12:1]};
        st_d.tx_idx = st_q.tx_idx + 4'h1;
      end else if (tx_go) begin
        st_d.tx_sh   = bf[12:0];
        st_d.tx_len  = bf[16:13];
        st_d.tx_idx  = 4'h0;
        st_d.tx_os   = 5'h0;
        st_d.tx_full = 1'b0;
        st_d.tx_st   = TX_SHIFT;
      end else if (tx_busy) begin
        st_d.tx_st   = TX_IDLE;
        st_d.tx_done = 1'b1;
      end
    end
    // write buffer fill
    if (i_tx_valid && !st_q.tx_full) begin
      st_d.tx_buf  = i_tx_data;
      st_d.tx_full = 1'b1;
    end
    // master clock output
    if (!is_mst) begin
      st_d.transfer_clock_pin = 1'b0;
    end else if (tick) begin
      if (st_q.transfer_clock_pin) st_d.transfer_clock_pin = 1'b0;
      else if (mchg && !(tx_last && !tx_go)) st_d.transfer_clock_pin = 1'b1;
    end
    st_d.xck_in_q = i_xck;
    // line low-pass filter
    if (tick) st_d.flt = {st_q.flt[1:0], i_rxd};
    // receiver sequence
    unique case (st_q.rx_st)
      RX_IDLE: begin
        if (is_spi) begin
          if (fall && tx_busy) begin
            take = 1'b1;
            pos  = 4'h0;
          end
        end else if (is_sync) begin
          if (fall && !i_rxd) begin
            st_d.rx_st  = RX_DATA;
            st_d.rx_idx = 4'h0;
          end
        end else if (tick && !maj) begin
          st_d.rx_st = RX_START;
          st_d.rx_os = 5'h0;
        end
      end
      RX_START: begin
        if (tick) begin
          if (st_q.rx_os == (os_n >> 1) - 5'h1) begin
            st_d.rx_st  = maj ? RX_IDLE : RX_DATA;
            st_d.rx_idx = 4'h0;
            st_d.rx_os  = 5'h0;
          end else begin
            st_d.rx_os = st_q.rx_os + 5'h1;
          end
        end
      end
      RX_DATA: begin
        if (is_sync) begin
          take = fall;
          val  = i_rxd;
        end else if (tick) begin
          if (st_q.rx_os == os_n - 5'h1) begin
            take       = 1'b1;
            st_d.rx_os = 5'h0;
          end else begin
            st_d.rx_os = st_q.rx_os + 5'h1;
          end
        end
      end
      default: st_d.rx_st = RX_IDLE;
    endcase
    // store sampled bit
    if (take) begin
      st_d.rx_sh[pos] = val;
      if (pos == target - 4'h1) begin
        fin        = 1'b1;
        st_d.rx_st = RX_IDLE;
      end else begin
        st_d.rx_idx = pos + 4'h1;
        st_d.rx_st  = RX_DATA;
      end
    end
    if (!i_rx_enable) st_d.rx_st = RX_IDLE;
    // received character checks
    word.data = 9'(st_d.rx_sh & mask11(n_bits));
    if (is_spi && i_msb_first && !i_ext_len_en) word.data = {1'b0, rev8(st_d.rx_sh[7:0])};
    word.perr = par & ((^(st_d.rx_sh & mask11(n_bits + 4'h1))) != i_parity_odd);
    word.ferr = ~is_spi & ~st_d.rx_sh[n_bits + {3'h0, par}];
    drop      = i_multiproc & ~is_spi & ~st_d.rx_sh[n_bits - 4'h1];
    // receive buffer read
    if (pop) begin
      st_d.rd  = ~st_q.rd;
      st_d.cnt = st_q.cnt - 2'h1;
      st_d.ovf = 1'b0;
    end
    // receive buffer write or overflow
    if (fin && !drop) begin
      if (st_q.cnt != 2'h2 || pop) begin
        st_d.ent[st_q.wr] = word;
        st_d.wr           = ~st_q.wr;
        st_d.cnt          = st_d.cnt + 2'h1;
      end else begin
        st_d.ovf = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= '0;
      st_q.tx_st <= TX_IDLE;
      st_q.rx_st <= RX_IDLE;
      st_q.flt   <= `USC_FLT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs
  assign line            = tx_busy ? st_q.tx_sh[0] : 1'b1;
  assign o_txd           = line | i_one_wire;
  assign o_rxd_out       = line;
  assign o_rxd_oe        = i_one_wire & tx_busy;
  assign o_xck           = st_q.transfer_clock_pin;
  assign o_xck_oe        = is_mst;
  assign o_tx_ready      = ~st_q.tx_full;
  assign o_data_empty    = ~st_q.tx_full;
  assign o_tx_complete   = st_q.tx_done;
  assign o_rx_valid      = (st_q.cnt != 2'h0);
  assign o_rx_complete   = (st_q.cnt != 2'h0);
  assign o_rx_data       = st_q.ent[st_q.rd].data;
  assign o_rx_frame_err  = st_q.ent[st_q.rd].ferr;
  assign o_rx_parity_err = st_q.ent[st_q.rd].perr;
  assign o_rx_overflow   = st_q.ovf;
endmodule : usc_core

// ==== usc_core_sva.sv ====
// checker for the serial transceiver core port behaviour
// assumes binding onto usc_core; sees its ports only
`timescale 1ns/1ps
module usc_core_sva (
  // clock, reset and controls
  input wire logic               i_clk,
  input wire logic               i_arst_n,
  input wire usc_pkg::usc_mode_t i_clock_mode,
  input wire logic               i_tx_valid,
  input wire logic               i_rx_ready,
  input wire logic               i_one_wire,
  // watched outputs
  input wire logic               o_tx_ready,
  input wire logic               o_data_empty,
  input wire logic               o_rx_valid,
  input wire logic               o_rx_complete,
  input wire logic [8:0]         o_rx_data,
  input wire logic               o_rx_overflow,
  input wire logic               o_rx_frame_err,
  input wire logic               o_txd,
  input wire logic               o_rxd_oe,
  input wire logic               o_xck,
  input wire logic               o_xck_oe
);
  import usc_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // write handshake and buffer state
  a_take_clears_ready: assert property (i_tx_valid && o_tx_ready |=> !o_tx_ready && !o_data_empty)
    else $error("ready stayed high after a write");
  a_empty_tracks_ready: assert property (o_data_empty == o_tx_ready)
    else $error("buffer empty differs from ready");
  a_rxc_level: assert property (o_rx_complete == o_rx_valid)
    else $error("receive complete differs from valid");
  // receive head and overflow
  a_rx_head_hold: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data))
    else $error("receive head moved without a read");
  a_ovf_sticky: assert property (o_rx_overflow && !(o_rx_valid && i_rx_ready) |=> o_rx_overflow)
    else $error("overflow dropped without a read");
  a_ovf_needs_full: assert property ($rose(o_rx_overflow) |-> o_rx_valid)
    else $error("overflow with an empty buffer");
  // line and clock pins
  a_async_bit_len: assert property ($fell(o_txd) && i_clock_mode == USC_ASYNC && !i_one_wire |-> !o_txd [*8])
    else $error("asynchronous bit shorter than eight clocks");
  a_xck_oe_mode: assert property ($stable(i_clock_mode) |->
                                  o_xck_oe == (i_clock_mode == USC_SYNC_MST || i_clock_mode == USC_SPI_MST))
    else $error("clock pin enable does not follow mode");
  a_async_no_clock: assert property (i_clock_mode == USC_ASYNC && $past(i_clock_mode) == USC_ASYNC |-> !o_xck)
    else $error("clock pin toggles in asynchronous mode");
  a_no_oe_two_wire: assert property (!i_one_wire && !$past(i_one_wire) |-> !o_rxd_oe)
    else $error("receive pin driven outside one-wire mode");
  // main scenarios reached
  c_write: cover property (i_tx_valid && o_tx_ready);
  c_overflow: cover property ($rose(o_rx_overflow));
  c_frame_err: cover property ($rose(o_rx_frame_err));
  c_xck: cover property ($rose(o_xck));
endmodule : usc_core_sva

bind usc_core usc_core_sva i_sva (.i_clk, .i_arst_n, .i_clock_mode, .i_tx_valid, .i_rx_ready, .i_one_wire,
  .o_tx_ready, .o_data_empty, .o_rx_valid, .o_rx_complete, .o_rx_data, .o_rx_overflow, .o_rx_frame_err,
  .o_txd, .o_rxd_oe, .o_xck, .o_xck_oe);

// ==== usc_pkg.sv ====
// types shared by the serial transceiver core and its rate generator
// assumes usc_regs.svh on the include path
package usc_pkg;
  `include "usc_regs.svh"
  // clock generation modes, one-hot
  typedef enum logic [3:0] {
    USC_ASYNC    = 4'h1,
    USC_SYNC_MST = 4'h2,
    USC_SYNC_SLV = 4'h4,
    USC_SPI_MST  = 4'h8
  } usc_mode_t;
  typedef enum logic [1:0] {TX_IDLE = 2'h1, TX_SHIFT = 2'h2} usc_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE = 3'h1, RX_START = 3'h2, RX_DATA = 3'h4} usc_rx_st_t;
  // one receive buffer entry
  typedef struct packed {
    logic       perr;
    logic       ferr;
    logic [8:0] data;
  } usc_rx_ent_t;
endpackage : usc_pkg

// ==== usc_regs.svh ====
// constants for the serial transceiver core: oversampling, widths, reset values
// assumes inclusion by bare name from the package
`ifndef USC_REGS_SVH
`define USC_REGS_SVH
`define USC_OS_NORMAL  5'h10
`define USC_OS_DOUBLE  5'h08
`define USC_PERIOD_W   12
`define USC_CNT_W      20
`define USC_FRAC_W     7
`define USC_SPI_BITS   4'h8
`define USC_MAX_BITS   4'h9
`define USC_FLT_RST    3'h7
`endif

// ==== usc_serial_peer.sv ====
// serial peer: asynchronous receiver on the core's line, sender towards it
// assumes the bench sets bit_clks to the core's bit length before traffic
`timescale 1ns/1ps
module usc_serial_peer (
  // clock
  input  wire logic i_clk,
  // lines
  input  wire logic i_line,
  output logic      o_line
);
  int         bit_clks = 32;
  bit         rx_on    = 1'b1;
  logic [7:0] got[$];
  logic [7:0] sh;
  // receiver: centre sampling of eight bits, false starts dropped
  initial begin
    o_line = 1'b1;
    forever begin
      @(negedge i_line);
      if (rx_on) begin
        repeat (bit_clks / 2) @(posedge i_clk);
        if (!i_line) begin
          for (int k = 0; k < 8; k++) begin
            repeat (bit_clks) @(posedge i_clk);
            sh[k] = i_line;
          end
          got.push_back(sh);
          repeat (bit_clks) @(posedge i_clk);  // into the stop bit
        end
      end
    end
  end
  // sender: start, data lsb first, optional parity, stop, then one idle bit with parity and one without
  task automatic send(input logic [7:0] d, input logic par, input logic pbit, input logic stp);
    logic [10:0] f;
    f = par ? {stp, pbit, d, 1'b0} : {1'b1, stp, d, 1'b0};
    for (int i = 0; i < (par ? 11 : 10); i++) begin
      o_line <= f[i];
      repeat (bit_clks) @(posedge i_clk);
    end
    o_line <= 1'b1;  // idle is high
    repeat (bit_clks) @(posedge i_clk);
  endtask : send
endmodule : usc_serial_peer
